// file: rtl/mcs_regs.vh
/*
  Register indices, field positions, reset values and timing figures of the
  monitor conversion sequencer.
  Assumes it is included by bare name; the APB byte address is index * 4.
*/
`ifndef MCS_REGS_VH
`define MCS_REGS_VH

// ----------------------------------------------------------------------
// Register indices (also the SMBus command byte)
// ----------------------------------------------------------------------
`define MCS_IDX_TEMP       8'h00
`define MCS_IDX_TEMP_EXT   8'h03
`define MCS_IDX_VOLT       8'h06
`define MCS_IDX_STAT       8'h0a
`define MCS_IDX_CFG        8'h0b
`define MCS_IDX_RATE       8'h0c
`define MCS_IDX_T_UPPER    8'h0d
`define MCS_IDX_T_LOWER    8'h10
`define MCS_IDX_PTR        8'h13

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MCS_STAT_BUSY_BIT  7
`define MCS_CFG_STOP_BIT   6
`define MCS_CFG_TDIS_BIT   5
`define MCS_CFG_VDIS_BIT   4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MCS_RST_PTR        8'h00
`define MCS_RST_T_UPPER    8'h7f
`define MCS_RST_T_LOWER    8'hc9
`define MCS_RST_RATE       4'h2
`define MCS_SMB_ADDR       7'h4c

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MCS_CLK_PERIOD_NS  25
`define MCS_TEMP_CONV_US   125000
`define MCS_VOLT_CONV_US   62500
`define MCS_RATE_STEP_US   62500

`endif

// file: rtl/mcs_sync.v
/*
  Two-flop synchroniser for a group of independent pin levels.
  Assumes each bit is a slow level from outside the CLK domain.
*/
module mcs_sync #(
  parameter         W    = 1,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         ce,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_q;

  always @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= INIT;
      q      <= INIT;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// file: rtl/mcs_smb.v
/*
  SMBus byte slave: Write Byte, Read Byte, Send Byte and Receive Byte.
  Assumes scl and sda are already synchronised to clk; sda is open drain.
*/
`include "mcs_regs.vh"
module mcs_smb #(
  parameter [6:0] ADDR = 7'h4c
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       scl,
  input  wire       sda,
  input  wire [7:0] rd_data,
  output reg  [7:0] ptr,
  output reg        wr_stb,
  output reg  [7:0] wr_data,
  output reg        sda_oe
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_RX   = 3'd1;
  localparam [2:0] S_ACK  = 3'd2;
  localparam [2:0] S_TX   = 3'd3;
  localparam [2:0] S_MACK = 3'd4;

  reg [2:0] st_q;
  reg [3:0] bitn_q;
  reg [7:0] sr_q;
  reg [1:0] nbyte_q;
  reg       rd_q;
  reg       scl_p;
  reg       sda_p;

  wire scl_r = scl & ~scl_p;
  wire scl_f = ~scl & scl_p;
  wire start = scl & scl_p & sda_p & ~sda;
  wire stop  = scl & scl_p & ~sda_p & sda;

  always @(posedge clk) begin
    if (!rst_n) begin
      st_q    <= S_IDLE;
      bitn_q  <= 4'h0;
      sr_q    <= 8'h00;
      nbyte_q <= 2'd0;
      rd_q    <= 1'b0;
      scl_p   <= 1'b1;
      sda_p   <= 1'b1;
      ptr     <= `MCS_RST_PTR;
      wr_stb  <= 1'b0;
      wr_data <= 8'h00;
      sda_oe  <= 1'b0;
    end else if (ce) begin
      scl_p  <= scl;
      sda_p  <= sda;
      wr_stb <= 1'b0;
      if (start) begin
        st_q    <= S_RX;
        bitn_q  <= 4'h0;
        nbyte_q <= 2'd0;
        sda_oe  <= 1'b0;
      end else if (stop) begin
        st_q   <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (st_q)
          S_RX: begin
            if (scl_r) begin
              sr_q   <= {sr_q[6:0], sda};
              bitn_q <= bitn_q + 4'h1;
            end else if (scl_f && bitn_q == 4'h8) begin
              // Address, command, then data byte, each acknowledged
              if (nbyte_q == 2'd0 && sr_q[7:1] != ADDR) begin
                st_q <= S_IDLE;
              end else if (nbyte_q == 2'd3) begin
                st_q <= S_IDLE;
              end else begin
                st_q    <= S_ACK;
                sda_oe  <= 1'b1;
                nbyte_q <= nbyte_q + 2'd1;
                if (nbyte_q == 2'd0)
                  rd_q <= sr_q[0];
                if (nbyte_q == 2'd1)
                  ptr <= sr_q;
                if (nbyte_q == 2'd2) begin
                  wr_stb  <= 1'b1;
                  wr_data <= sr_q;
                  nbyte_q <= 2'd3;
                end
              end
            end
          end
          S_ACK: begin
            if (scl_f) begin
              bitn_q <= 4'h0;
              if (rd_q) begin
                st_q   <= S_TX;
                sda_oe <= ~rd_data[7];
                sr_q   <= {rd_data[6:0], 1'b0};
              end else begin
                st_q   <= S_RX;
                sda_oe <= 1'b0;
              end
            end
          end
          S_TX: begin
            if (scl_f) begin
              if (bitn_q == 4'h7) begin
                st_q   <= S_MACK;
                sda_oe <= 1'b0;
              end else begin
                sda_oe <= ~sr_q[7];
                sr_q   <= {sr_q[6:0], 1'b0};
                bitn_q <= bitn_q + 4'h1;
              end
            end
          end
          S_MACK: begin
            // Not-acknowledge ends the read; acknowledge sends the byte again
            if (scl_r)
              st_q <= sda ? S_IDLE : S_ACK;
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

endmodule

// file: rtl/mcs_top.v
/*
  Conversion sequencer of a temperature and voltage monitor with an APB
  register slave and an SMBus byte slave sharing one register file.
  Assumes an analog front end on CLK that converts ADC_CHANNEL while
  ADC_RUN is high and presents its result on ADC_DATA at the slot end.
*/
// Notes on behaviour
// - Each temperature result is stored and compared with upper and lower limits.
// - Temperature results readable any time with 11-bit resolution.
// - Voltage channels give unsigned 8-bit codes, nominal input near 198.
// - Temperature slot lasts 125 ms, voltage slot 62.5 ms.
// - A cycle converts all enabled channels; results appear at cycle end.
// - Busy flag high while a cycle runs, low otherwise.
// - During a cycle, reads return previous cycle's results.
// - Order: remote one, remote two, local, voltage three, then variant order.
// - Slots always full speed; only the idle gap follows the rate register.
// - Disabled temperature or voltage channels are skipped.
// - Standby stops all conversion activity.
// - Standby from pin or software stop bit, identical behaviour.
// - Standby keeps stored data and serves bus reads and writes.
// - Standby pin low overrides any software run request.
// - Standby during a cycle aborts it, discarding partial results.
// - Command pointer is zero after reset.
// - Busy flag is the top bit of the status register.
`include "mcs_regs.vh"

module mcs_top #(
  parameter [31:0] TEMP_CYC  = `MCS_TEMP_CONV_US * 1000 / `MCS_CLK_PERIOD_NS,
  parameter [31:0] VOLT_CYC  = `MCS_VOLT_CONV_US * 1000 / `MCS_CLK_PERIOD_NS,
  parameter [31:0] RATE_CYC  = `MCS_RATE_STEP_US * 1000 / `MCS_CLK_PERIOD_NS,
  parameter [6:0]  SMB_ADDR  = `MCS_SMB_ADDR,
  parameter        ALT_ORDER = 0
) (
  input  wire        CLK,
  input  wire        RESET_N,
  input  wire        CE,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        STANDBY_PIN_N,
  input  wire        SMB_SCL,
  input  wire        SMB_SDA,
  output reg         SMB_SDA_O,
  output wire        SMB_SDA_OE,
  input  wire [10:0] ADC_DATA,
  output reg         ADC_RUN,
  output reg  [2:0]  ADC_CHANNEL,
  output reg         CONV_BUSY
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam [1:0] ST_STANDBY_PIN_N  = 2'd0;
  localparam [1:0] ST_WAIT  = 2'd1;
  localparam [1:0] ST_CONV  = 2'd2;
  localparam [1:0] ST_DONE  = 2'd3;
  localparam [2:0] POS_NONE = 3'd7;

  reg  [1:0]  st_q;
  reg  [2:0]  pos_q;
  reg  [31:0] cnt_q;
  reg  [2:0]  tmask_q;
  reg  [3:0]  vmask_q;
  reg  [10:0] sh_t  [0:2];
  reg  [7:0]  sh_v  [0:3];
  reg  [10:0] res_t [0:2];
  reg  [7:0]  res_v [0:3];
  reg  [7:0]  hi_q  [0:2];
  reg  [7:0]  lo_q  [0:2];
  reg  [5:0]  flag_q;
  reg  [5:0]  flag_set;
  reg         cfg_stop_q;
  reg         cfg_tdis_q;
  reg         cfg_vdis_q;
  reg  [3:0]  rate_q;
  wire [2:0]  pin_s;
  wire [7:0]  smb_ptr;
  wire        smb_wr;
  wire [7:0]  smb_wdat;
  integer     i;
  integer     j;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Result slot of a temperature position: 0 local, 1 remote one, 2 remote two
  function [1:0] tslot;
    input [2:0] pos;
    begin
      tslot = (pos == 3'd2) ? 2'd0 : pos[1:0] + 2'd1;
    end
  endfunction

  // Result slot of a voltage position: 0 input one, 1 two, 2 three, 3 supply
  function [1:0] vslot;
    input [2:0] pos;
    begin
      case (pos)
        3'd3:    vslot = 2'd2;
        3'd4:    vslot = ALT_ORDER ? 2'd3 : 2'd1;
        3'd5:    vslot = 2'd0;
        default: vslot = ALT_ORDER ? 2'd1 : 2'd3;
      endcase
    end
  endfunction

  // First enabled position at or after from, or none
  function [2:0] next_on;
    input [3:0] from;
    input       tdis;
    input       vdis;
    integer     k;
    begin
      next_on = POS_NONE;
      for (k = 6; k >= 0; k = k - 1)
        if (k >= from && !((k < 3) ? tdis : vdis))
          next_on = k[2:0];
    end
  endfunction

  function [7:0] rd_byte;
    input [7:0] idx;
    reg   [7:0] off;
    begin
      off     = 8'h00;
      rd_byte = 8'h00;
      if (idx < `MCS_IDX_TEMP_EXT) begin
        rd_byte = res_t[idx[1:0]][10:3];
      end else if (idx < `MCS_IDX_VOLT) begin
        off     = idx - `MCS_IDX_TEMP_EXT;
        rd_byte = {res_t[off[1:0]][2:0], 5'h00};
      end else if (idx < `MCS_IDX_STAT) begin
        off     = idx - `MCS_IDX_VOLT;
        rd_byte = res_v[off[1:0]];
      end else if (idx == `MCS_IDX_STAT) begin
        rd_byte = {CONV_BUSY, 1'b0, flag_q};
      end else if (idx == `MCS_IDX_CFG) begin
        rd_byte = {1'b0, cfg_stop_q, cfg_tdis_q, cfg_vdis_q, 4'h0};
      end else if (idx == `MCS_IDX_RATE) begin
        rd_byte = {4'h0, rate_q};
      end else if (idx < `MCS_IDX_T_LOWER) begin
        off     = idx - `MCS_IDX_T_UPPER;
        rd_byte = hi_q[off[1:0]];
      end else if (idx < `MCS_IDX_PTR) begin
        off     = idx - `MCS_IDX_T_LOWER;
        rd_byte = lo_q[off[1:0]];
      end else if (idx == `MCS_IDX_PTR) begin
        rd_byte = smb_ptr;
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pins and SMBus slave
  // ----------------------------------------------------------------------
  mcs_sync #(
    .W    (3),
    .INIT (3'b111)
  ) u_sync (
    .clk   (CLK),
    .rst_n (RESET_N),
    .ce    (CE),
    .d     ({SMB_SDA, SMB_SCL, STANDBY_PIN_N}),
    .q     (pin_s)
  );

  mcs_smb #(
    .ADDR (SMB_ADDR)
  ) u_smb (
    .clk     (CLK),
    .rst_n   (RESET_N),
    .ce      (CE),
    .scl     (pin_s[1]),
    .sda     (pin_s[2]),
    .rd_data (rd_byte(smb_ptr)),
    .ptr     (smb_ptr),
    .wr_stb  (smb_wr),
    .wr_data (smb_wdat),
    .sda_oe  (SMB_SDA_OE)
  );

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  wire        standby  = ~pin_s[0] | cfg_stop_q;
  wire [3:0]  from_pos = (st_q == ST_CONV) ? {1'b0, pos_q} + 4'd1 : 4'd0;
  wire [2:0]  nxt_pos  = next_on(from_pos, cfg_tdis_q, cfg_vdis_q);
  wire        slot_end = (st_q == ST_WAIT || st_q == ST_CONV) && cnt_q == 32'h0;
  wire        launch   = slot_end && nxt_pos != POS_NONE;
  wire        commit   = st_q == ST_DONE && !standby;
  wire [35:0] idle_len = rate_q * RATE_CYC;

  always @(posedge CLK) begin
    if (!RESET_N) begin
      st_q        <= ST_STANDBY_PIN_N;
      pos_q       <= 3'd0;
      cnt_q       <= 32'h0;
      tmask_q     <= 3'h0;
      vmask_q     <= 4'h0;
      ADC_RUN     <= 1'b0;
      ADC_CHANNEL <= 3'd0;
      CONV_BUSY   <= 1'b0;
    end else if (CE) begin
      if (standby) begin
        st_q      <= ST_STANDBY_PIN_N;
        ADC_RUN   <= 1'b0;
        CONV_BUSY <= 1'b0;
        tmask_q   <= 3'h0;
        vmask_q   <= 4'h0;
      end else begin
        if (st_q == ST_CONV && cnt_q == 32'h0) begin
          if (pos_q < 3'd3) begin
            sh_t[tslot(pos_q)]    <= ADC_DATA;
            tmask_q[tslot(pos_q)] <= 1'b1;
          end else begin
            sh_v[vslot(pos_q)]    <= ADC_DATA[7:0];
            vmask_q[vslot(pos_q)] <= 1'b1;
          end
        end
        if (launch) begin
          st_q        <= ST_CONV;
          pos_q       <= nxt_pos;
          cnt_q       <= ((nxt_pos < 3'd3) ? TEMP_CYC : VOLT_CYC) - 32'd1;
          ADC_CHANNEL <= (nxt_pos < 3'd3) ? nxt_pos : {1'b0, vslot(nxt_pos)} + 3'd3;
          ADC_RUN     <= 1'b1;
          CONV_BUSY   <= 1'b1;
        end else begin
          case (st_q)
            ST_STANDBY_PIN_N: begin
              st_q  <= ST_WAIT;
              cnt_q <= 32'h0;
            end
            ST_WAIT: begin
              if (cnt_q != 32'h0)
                cnt_q <= cnt_q - 32'd1;
            end
            ST_CONV: begin
              if (cnt_q != 32'h0) begin
                cnt_q <= cnt_q - 32'd1;
              end else begin
                st_q    <= ST_DONE;
                ADC_RUN <= 1'b0;
              end
            end
            ST_DONE: begin
              st_q      <= ST_WAIT;
              cnt_q     <= idle_len[31:0];
              CONV_BUSY <= 1'b0;
              tmask_q   <= 3'h0;
              vmask_q   <= 4'h0;
            end
            default: st_q <= ST_STANDBY_PIN_N;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register writes and APB slave
  // ----------------------------------------------------------------------
  wire       apb_ok   = PADDR[1:0] == 2'b00 && {2'b00, PADDR[7:2]} <= `MCS_IDX_PTR;
  wire       apb_wr   = PSEL && PENABLE && PWRITE && PREADY && apb_ok;
  wire       smb_ok   = smb_wr && smb_ptr < `MCS_IDX_PTR;
  wire       wr_go    = apb_wr || smb_ok;
  wire [7:0] wr_idx   = apb_wr ? {2'b00, PADDR[7:2]} : smb_ptr;
  wire [7:0] wr_dat   = apb_wr ? PWDATA[7:0] : smb_wdat;
  wire [7:0] off_up   = wr_idx - `MCS_IDX_T_UPPER;
  wire [7:0] off_lo   = wr_idx - `MCS_IDX_T_LOWER;
  wire [5:0] flag_clr = (wr_go && wr_idx == `MCS_IDX_STAT) ? wr_dat[5:0] : 6'h00;

  always @* begin
    flag_set = 6'h00;
    for (j = 0; j < 3; j = j + 1) begin
      flag_set[j + 3] = commit && tmask_q[j] && $signed(sh_t[j][10:3]) > $signed(hi_q[j]);
      flag_set[j]     = commit && tmask_q[j] && $signed(sh_t[j][10:3]) < $signed(lo_q[j]);
    end
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      for (i = 0; i < 3; i = i + 1) begin
        res_t[i] <= 11'h000;
        hi_q[i]  <= `MCS_RST_T_UPPER;
        lo_q[i]  <= `MCS_RST_T_LOWER;
      end
      for (i = 0; i < 4; i = i + 1)
        res_v[i] <= 8'h00;
      flag_q     <= 6'h00;
      cfg_stop_q <= 1'b0;
      cfg_tdis_q <= 1'b0;
      cfg_vdis_q <= 1'b0;
      rate_q     <= `MCS_RST_RATE;
      PRDATA     <= 32'h0;
      PREADY     <= 1'b0;
      PSLVERR    <= 1'b0;
      SMB_SDA_O  <= 1'b0;
    end else if (CE) begin
      if (commit) begin
        for (i = 0; i < 3; i = i + 1)
          if (tmask_q[i])
            res_t[i] <= sh_t[i];
        for (i = 0; i < 4; i = i + 1)
          if (vmask_q[i])
            res_v[i] <= sh_v[i];
      end
      // Hardware set wins over a same-cycle clear
      flag_q <= (flag_q & ~flag_clr) | flag_set;
      // Writes stay accepted in standby
      if (wr_go) begin
        if (wr_idx == `MCS_IDX_CFG) begin
          cfg_stop_q <= wr_dat[`MCS_CFG_STOP_BIT];
          cfg_tdis_q <= wr_dat[`MCS_CFG_TDIS_BIT];
          cfg_vdis_q <= wr_dat[`MCS_CFG_VDIS_BIT];
        end
        if (wr_idx == `MCS_IDX_RATE)
          rate_q <= wr_dat[3:0];
        if (wr_idx >= `MCS_IDX_T_UPPER && wr_idx < `MCS_IDX_T_LOWER)
          hi_q[off_up[1:0]] <= wr_dat;
        if (wr_idx >= `MCS_IDX_T_LOWER && wr_idx < `MCS_IDX_PTR)
          lo_q[off_lo[1:0]] <= wr_dat;
      end
      // One wait state: PREADY rises after the first access edge
      if (PSEL && PENABLE && !PREADY) begin
        PREADY  <= 1'b1;
        PSLVERR <= !apb_ok;
        PRDATA  <= apb_ok ? {24'h0, rd_byte({2'b00, PADDR[7:2]})} : 32'h0;
      end else begin
        PREADY  <= 1'b0;
        PSLVERR <= 1'b0;
      end
    end
  end

endmodule

// file: dv/mcs_smb_host.sv
/*
  SMBus host model: Write Byte and Read Byte.
  Assumes the bench resolves open-drain SDA into sda_in.
*/
module mcs_smb_host #(
  parameter [6:0] ADDR = 7'h4c,
  parameter       Q    = 25
) (
  input  wire clk,
  input  wire sda_in,
  output reg  scl,
  output reg  sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------
  // Bus phases, one line changed per phase
  // --------
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task ph(input s, input l);
    begin
      scl <= s;
      sda_low <= l;
      repeat (Q) @(posedge clk);
    end
  endtask
  task start;
    begin
      ph(1'b0, sda_low);
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
    end
  endtask
  task stop;
    begin
      ph(1'b0, sda_low);
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
    end
  endtask
  task bit_io(input b, output r);
    begin
      ph(1'b0, sda_low);
      ph(1'b0, !b);
      ph(1'b1, !b);
      r = sda_in;
      ph(1'b1, !b);
    end
  endtask
  // Ninth bit released: acknowledge or host NACK
  task byte_io(input [7:0] d, output [7:0] r, output ack);
    integer i;
    reg a;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_io(d[i], r[i]);
      bit_io(1'b1, a);
      ack = !a;
    end
  endtask
  task write_byte(input [7:0] cmd, input [7:0] dat, output ok);
    reg [7:0] r;
    reg a0, a1, a2;
    begin
      start;
      byte_io({ADDR, 1'b0}, r, a0);
      byte_io(cmd, r, a1);
      byte_io(dat, r, a2);
      stop;
      ok = a0 & a1 & a2;
    end
  endtask
  // Pointer selected first, no bare receive
  task read_byte(input [7:0] cmd, output [7:0] dat, output ok);
    reg [7:0] r;
    reg a0, a1, a2, a3;
    begin
      start;
      byte_io({ADDR, 1'b0}, r, a0);
      byte_io(cmd, r, a1);
      start;
      byte_io({ADDR, 1'b1}, r, a2);
      byte_io(8'hff, dat, a3);
      stop;
      ok = a0 & a1 & a2;
    end
  endtask
endmodule

// file: dv/mcs_top_assertions.sv
/*
  Assertions on sequencer and APB ports of mcs_top.
  Assumes one clock domain; bound at the foot.
*/
module mcs_chk #(
  parameter [31:0] TEMP_CYC = 20,
  parameter [31:0] VOLT_CYC = 10
) (
  input wire       CLK,
  input wire       RESET_N,
  input wire       CE,
  input wire       PSEL,
  input wire       PENABLE,
  input wire [7:0] PADDR,
  input wire       PREADY,
  input wire       PSLVERR,
  input wire       STANDBY_PIN_N,
  input wire       ADC_RUN,
  input wire [2:0] ADC_CHANNEL,
  input wire       CONV_BUSY
);
  timeunit 1ns;
  timeprecision 100ps;
  reg [31:0] cnt_q;
  reg [2:0]  ch_q;
  reg        run_q;
  // --------
  // Slot length counter
  // --------
  function [2:0] nxt(input [2:0] c);
    nxt = (c == 3'h2) ? 3'h5 : (c == 3'h3) ? 3'h6 : (c > 3'h3) ? c - 3'h1 : c + 3'h1;
  endfunction
  always @(posedge CLK) begin
    if (!RESET_N) begin
      cnt_q <= 32'h0;
      ch_q <= 3'h0;
      run_q <= 1'b0;
    end else begin
      cnt_q <= (ADC_RUN && run_q && ADC_CHANNEL == ch_q) ? cnt_q + 32'h1 : 32'h1;
      ch_q <= ADC_CHANNEL;
      run_q <= ADC_RUN;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  property p_busy_run; ADC_RUN |-> CONV_BUSY; endproperty
  a_busy_run: assert property (p_busy_run) else $error("run without busy");
  property p_order; ADC_RUN && run_q && ADC_CHANNEL != ch_q |-> ADC_CHANNEL == nxt(ch_q);
  endproperty
  a_order: assert property (p_order) else $error("channel order broken");
  property p_slot; ADC_RUN && run_q && ADC_CHANNEL != ch_q
    |-> cnt_q == ((ch_q < 3'h3) ? TEMP_CYC : VOLT_CYC); endproperty
  a_slot: assert property (p_slot) else $error("slot length wrong");
  property p_launch; $rose(ADC_RUN) |-> CONV_BUSY && (ADC_CHANNEL == 3'h0 || ADC_CHANNEL == 3'h5);
  endproperty
  a_launch: assert property (p_launch) else $error("bad first channel");
  property p_standby; !STANDBY_PIN_N [*6] |-> !ADC_RUN && !CONV_BUSY; endproperty
  a_standby: assert property (p_standby) else $error("converting in standby");
  property p_end; $fell(ADC_RUN) |=> !CONV_BUSY; endproperty
  a_end: assert property (p_end) else $error("busy stuck after cycle");
  property p_pulse; PREADY |=> !PREADY; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_wait; CE && PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  a_wait: assert property (p_wait) else $error("ready late");
  property p_err; PSLVERR |-> PREADY; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_unmap; CE && PSEL && PENABLE && !PREADY
    && (PADDR[1:0] != 2'h0 || PADDR[7:2] > 6'h13) |=> PSLVERR; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
endmodule

bind mcs_top mcs_chk #(.TEMP_CYC(TEMP_CYC), .VOLT_CYC(VOLT_CYC)) u_chk (
  .CLK(CLK), .RESET_N(RESET_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .STANDBY_PIN_N(STANDBY_PIN_N), .ADC_RUN(ADC_RUN),
  .ADC_CHANNEL(ADC_CHANNEL), .CONV_BUSY(CONV_BUSY));

// file: dv/monitor_conversion_sequencer_bench.sv
/*
  Self-checking bench of mcs_top: APB tasks, SMBus host, fake front end.
  Assumes shortened slot and rate counts.
*/
module monitor_conversion_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [31:0] RATE = 32'd5;
  reg         clk, reset_n, psel, penable, pwrite, standby_pin_n;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  reg  [2:0]  gen;
  wire [31:0] prdata;
  wire        pready, pslverr, sda_o, sda_oe, adc_run, busy, scl, sda_low;
  wire [2:0]  ch;
  integer     bad_count, compares, g1, g2;
  wire        sda = !(sda_low || (sda_oe && !sda_o));
  wire [10:0] adc = {gen, ch, gen[1:0], ch};

  mcs_top #(.TEMP_CYC(32'd20), .VOLT_CYC(32'd10), .RATE_CYC(RATE)) dut (
    .CLK(clk), .RESET_N(reset_n), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .STANDBY_PIN_N(standby_pin_n), .SMB_SCL(scl), .SMB_SDA(sda),
    .SMB_SDA_O(sda_o), .SMB_SDA_OE(sda_oe), .ADC_DATA(adc), .ADC_RUN(adc_run),
    .ADC_CHANNEL(ch), .CONV_BUSY(busy));
  mcs_smb_host #(.ADDR(7'h4c)) host (.clk(clk), .sda_in(sda), .scl(scl), .sda_low(sda_low));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // --------
  // Shared tasks
  // --------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input wr, input [7:0] a, input [7:0] wd, output [31:0] rd, output err);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
      chk({31'h0, pready}, 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [5:0] idx, input [7:0] exp);
    reg [31:0] d;
    reg e;
    begin
      apb(1'b0, {idx, 2'b00}, 8'h00, d, e);
      chk(d, {24'h0, exp});
    end
  endtask
  task wr(input [5:0] idx, input [7:0] v);
    reg [31:0] d;
    reg e;
    apb(1'b1, {idx, 2'b00}, v, d, e);
  endtask
  // Expected byte at index i for front-end generation g
  function [7:0] res(input [3:0] i, input [2:0] g);
    reg [2:0] c;
    begin
      c = i[2:0] - 3'h3;
      case (i)
        4'h0: res = {g, 3'h2, g[1:0]};
        4'h1: res = {g, 3'h0, g[1:0]};
        4'h2: res = {g, 3'h1, g[1:0]};
        4'h3: res = 8'h40;
        4'h4: res = 8'h00;
        4'h5: res = 8'h20;
        default: res = {c, g[1:0], c};
      endcase
    end
  endfunction
  task all_res(input [2:0] g);
    integer i;
    for (i = 0; i < 10; i = i + 1)
      rd(i[5:0], res(i[3:0], g));
  endtask
  task wait_busy(input lvl);
    integer n;
    begin
      n = 0;
      while (busy !== lvl && n < 3000) begin
        @(posedge clk);
        n = n + 1;
      end
      chk({31'h0, busy}, {31'h0, lvl});
    end
  endtask
  task quiet(input integer n);
    integer k;
    begin
      k = 0;
      repeat (n) begin
        @(posedge clk);
        if (adc_run !== 1'b0 || busy !== 1'b0)
          k = k + 1;
      end
      chk(k, 0);
    end
  endtask
  task gap(output integer n);
    begin
      wait_busy(1'b1);
      wait_busy(1'b0);
      n = 0;
      while (adc_run !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n = n + 1;
      end
    end
  endtask
  // --------
  // Scenarios
  // --------
  task t_regs;
    reg [31:0] d;
    reg e;
    begin
      rd(6'h13, 8'h00);
      rd(6'h0d, 8'h7f);
      rd(6'h10, 8'hc9);
      apb(1'b0, 8'h50, 8'h00, d, e);
      chk({e, d[30:0]}, 32'h80000000);
      apb(1'b1, 8'h31, 8'h09, d, e);
      chk({31'h0, e}, 32'h1);
      rd(6'h0c, 8'h02);
    end
  endtask
  task t_cycle;
    begin
      wait_busy(1'b1);
      wait_busy(1'b0);
      all_res(3'h1);
      gen <= 3'h2;
      wait_busy(1'b1);
      rd(6'h0a, 8'h80);
      all_res(3'h1);
      wait_busy(1'b0);
      rd(6'h00, res(4'h0, 3'h2));
    end
  endtask
  task t_rate;
    begin
      gap(g1);
      wr(6'h0c, 8'h04);
      rd(6'h0c, 8'h04);
      gap(g2);
      chk(g2 - g1, 2 * RATE);
    end
  endtask
  task t_stop;
    reg ok;
    reg [7:0] d;
    begin
      wait_busy(1'b0);
      gen <= 3'h3;
      wait_busy(1'b1);
      repeat (30) @(posedge clk);
      wr(6'h0b, 8'h40);
      repeat (2) @(posedge clk);
      quiet(100);
      all_res(3'h2);
      host.write_byte(8'h0d, 8'h00, ok);
      chk({31'h0, ok}, 32'h1);
      host.read_byte(8'h0d, d, ok);
      chk({23'h0, ok, d}, 32'h100);
      host.read_byte(8'h00, d, ok);
      chk({23'h0, ok, d}, {24'h1, res(4'h0, 3'h2)});
      wr(6'h0b, 8'h00);
      wait_busy(1'b1);
      wait_busy(1'b0);
      rd(6'h0a, 8'h08);
      all_res(3'h3);
    end
  endtask
  task t_pin;
    begin
      gen <= 3'h4;
      wait_busy(1'b1);
      repeat (10) @(posedge clk);
      standby_pin_n <= 1'b0;
      wr(6'h0b, 8'h00);
      repeat (3) @(posedge clk);
      quiet(100);
      rd(6'h00, res(4'h0, 3'h3));
      standby_pin_n <= 1'b1;
      wait_busy(1'b1);
      wait_busy(1'b0);
      rd(6'h00, res(4'h0, 3'h4));
    end
  endtask
  task t_dis;
    begin
      wr(6'h0b, 8'h20);
      gen <= 3'h5;
      wait_busy(1'b1);
      chk({29'h0, ch}, 32'h5);
      wait_busy(1'b0);
      rd(6'h00, res(4'h0, 3'h4));
      rd(6'h06, res(4'h6, 3'h5));
    end
  endtask
  task tally_and_finish;
    begin
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // --------
  // Main sequence and watchdog
  // --------
  initial begin
    bad_count = 0;
    compares = 0;
    gen = 3'h1;
    reset_n = 1'b0;
    standby_pin_n = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = 43'h0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_cycle;
    t_rate;
    t_stop;
    t_pin;
    t_dis;
    tally_and_finish;
  end
  initial begin
    repeat (40000) @(posedge clk);
    bad_count = bad_count + 1;
    tally_and_finish;
  end
endmodule
